// [rtl/pst_pkg.sv]
package pst_pkg;
    // operation codes carried on the link
    localparam logic [2:0] OP_KILL  = 3'h0;
    localparam logic [2:0] OP_LOAD  = 3'h1;
    localparam logic [2:0] OP_PAD   = 3'h2;
    localparam logic [2:0] OP_DEPTH = 3'h3;
    localparam logic [2:0] OP_END   = 3'h4;
    // fixed point coordinate format, signed
    localparam int         FRAC     = 8;
    localparam logic [15:0] FX_ONE  = 16'h0100;
    localparam int         NREG     = 8;
    localparam logic [1:0] DZ_MAX   = 2'h2;
    // apb register offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DEPTH  = 8'h08;
    // command word fields
    localparam int C_OP    = 0;
    localparam int C_SRC   = 3;
    localparam int C_TMP   = 6;
    localparam int C_DST   = 7;
    localparam int C_XYW   = 10;
    localparam int C_DW    = 11;
    localparam int C_DZ    = 12;
    localparam int C_PH2   = 13;
    localparam int C_V14   = 14;
    localparam int C_START = 15;
    // status word fields
    localparam int S_PEND   = 0;
    localparam int S_KILLED = 1;
    localparam int S_ERR    = 2;
    localparam int S_DZCNT  = 8;
    localparam int NERR     = 6;
    localparam logic [31:0] RST_WORD = 32'h0;
endpackage

// [rtl/pst_if.sv]
`timescale 1ns/100ps
interface pst_if;
    logic        op_valid;
    logic        op_ready;
    logic [2:0]  op_code;
    logic [2:0]  op_src;
    logic        op_src_temp;
    logic [2:0]  op_dst;
    logic        op_xyw;
    logic        op_dw;
    logic        op_dz;
    logic        op_v14;
    logic        res_done;
    logic        res_killed;
    logic [15:0] res_depth;
    modport dev (input op_valid, op_code, op_src, op_src_temp, op_dst, op_xyw, op_dw,
                 op_dz, op_v14, output op_ready, res_done, res_killed, res_depth);
    modport iss (output op_valid, op_code, op_src, op_src_temp, op_dst, op_xyw, op_dw,
                 op_dz, op_v14, input op_ready, res_done, res_killed, res_depth);
endinterface

// [rtl/pst_device.sv]
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module pst_device #(
    parameter int DW = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    pst_if.dev                     link,
    output logic [2:0]             iter_sel,
    input  wire logic [4*DW-1:0]   iter_coord,
    output logic                   samp_req,
    output logic [2:0]             samp_stage,
    output logic [3*DW-1:0]        samp_coord,
    input  wire logic              samp_ack,
    input  wire logic [4*DW-1:0]   samp_rgba,
    input  wire logic [DW-1:0]     interp_depth,
    output logic                   pix_valid,
    output logic                   pix_color_we,
    output logic                   pix_depth_we,
    output logic                   pix_depth_replace,
    output logic [4*DW-1:0]        pix_color,
    output logic [DW-1:0]          pix_depth
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_SAMP = 4'b0100,
        ST_RESP = 4'b1000
    } pst_state_e;

    typedef logic signed [DW-1:0] pst_fx_t;

    pst_state_e          state;
    logic [2:0]          r_code;
    logic [2:0]          r_src;
    logic                r_tmp;
    logic [2:0]          r_dst;
    logic                r_xyw;
    logic                r_dw;
    logic                r_dz;
    logic                r_v14;
    logic [4*DW-1:0]     regs [pst_pkg::NREG];
    logic                kill_flag;
    logic                depth_tag;
    pst_fx_t             depth_val;
    pst_fx_t             z_hold;
    logic [4*DW-1:0]     src_vec;
    pst_fx_t             sx, sy, sz, sw;
    pst_fx_t             w_dot;
    pst_fx_t             depth_res;
    logic                neg_any;
    logic [3*DW-1:0]     next_coord;

    // fixed point divide; zero divisor gives zero so no unknowns escape
    function automatic pst_fx_t fx_div(input pst_fx_t a, input pst_fx_t b);
        logic signed [DW+pst_pkg::FRAC-1:0] n;
        logic signed [DW+pst_pkg::FRAC-1:0] d;
        logic signed [DW+pst_pkg::FRAC-1:0] q;
        n = {a, {pst_pkg::FRAC{1'b0}}};
        d = {{pst_pkg::FRAC{b[DW-1]}}, b};
        q = (b == '0) ? '0 : n / d;
        return q[DW-1:0];
    endfunction

    // three component dot product of stage uvw with register rgb
    function automatic pst_fx_t fx_dot3(input logic [4*DW-1:0] p, input logic [4*DW-1:0] q);
        logic signed [2*DW+1:0] acc;
        acc = '0;
        for (int i = 0; i < 3; i++) begin
            // widen before the multiply so the product keeps its upper bits
            acc = acc + (2*DW+2)'($signed(p[i*DW +: DW]))
                      * (2*DW+2)'($signed(q[i*DW +: DW]));
        end
        return acc[pst_pkg::FRAC +: DW];
    endfunction

    // iterator index: stage m for pad, m+1 for depth, else the source
    always_comb begin
        iter_sel = r_src;
        if (r_code == pst_pkg::OP_PAD || r_code == pst_pkg::OP_DEPTH) begin
            iter_sel = r_dst;
        end
    end

    // operand select: before 1.4 kill always reads the iterator set
    always_comb begin
        src_vec = iter_coord;
        if (r_code == pst_pkg::OP_KILL) begin
            if (r_v14 && r_tmp) begin
                src_vec = regs[r_src];
            end
        end else if (r_tmp) begin
            src_vec = regs[r_src];
        end
    end

    assign sx = src_vec[0*DW +: DW];
    assign sy = src_vec[1*DW +: DW];
    assign sz = src_vec[2*DW +: DW];
    assign sw = src_vec[3*DW +: DW];
    assign neg_any = sx[DW-1] | sy[DW-1] | sz[DW-1];

    // depth row: w from stage m+1 against the same source as the pad
    assign w_dot = fx_dot3(iter_coord, regs[r_src]);
    assign depth_res = (w_dot == '0) ? pst_fx_t'(pst_pkg::FX_ONE)
                                     : fx_div(z_hold, w_dot);

    // load coordinates; no implicit projection, only the modifiers divide
    always_comb begin
        next_coord = {(r_xyw ? sw : sz), sy, sx};
        if (r_dw) begin
            next_coord = {sw, fx_div(sy, sw), fx_div(sx, sw)};
        end else if (r_dz) begin
            next_coord = {sz, fx_div(sy, sz), fx_div(sx, sz)};
        end
    end

    // operation sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (link.op_valid) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= (r_code == pst_pkg::OP_LOAD) ? ST_SAMP : ST_RESP;
                end
                ST_SAMP: begin
                    if (samp_ack) begin
                        state <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // operation latch, taken on the link handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_code <= '0;
            r_src  <= '0;
            r_tmp  <= 1'b0;
            r_dst  <= '0;
            r_xyw  <= 1'b0;
            r_dw   <= 1'b0;
            r_dz   <= 1'b0;
            r_v14  <= 1'b0;
        end else if (state == ST_IDLE && link.op_valid) begin
            r_code <= link.op_code;
            r_src  <= link.op_src;
            r_tmp  <= link.op_src_temp;
            r_dst  <= link.op_dst;
            r_xyw  <= link.op_xyw;
            r_dw   <= link.op_dw;
            r_dz   <= link.op_dz;
            r_v14  <= link.op_v14;
        end
    end

    // sampler request coordinates held for the whole wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_coord <= '0;
            samp_stage <= '0;
        end else if (state == ST_EXEC && r_code == pst_pkg::OP_LOAD) begin
            samp_coord <= next_coord;
            samp_stage <= r_dst;
        end
    end

    // register file: sampled colour or computed depth
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pst_pkg::NREG; i++) begin
                regs[i] <= '0;
            end
        end else if (state == ST_SAMP && samp_ack) begin
            regs[r_dst] <= samp_rgba;
        end else if (state == ST_EXEC && r_code == pst_pkg::OP_DEPTH) begin
            regs[r_dst] <= {4{depth_res}};
        end
    end

    // per-pixel state: kill flag, first depth row, depth tag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kill_flag <= 1'b0;
            depth_tag <= 1'b0;
            depth_val <= '0;
            z_hold    <= '0;
        end else if (state == ST_EXEC) begin
            unique case (r_code)
                pst_pkg::OP_KILL: begin
                    if (neg_any) begin
                        kill_flag <= 1'b1;
                    end
                end
                pst_pkg::OP_PAD: begin
                    z_hold <= fx_dot3(iter_coord, regs[r_src]);
                end
                pst_pkg::OP_DEPTH: begin
                    depth_tag <= 1'b1;
                    depth_val <= depth_res;
                end
                pst_pkg::OP_END: begin
                    kill_flag <= 1'b0;
                    depth_tag <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // pixel retire: one decision and one depth for all sub-samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_valid         <= 1'b0;
            pix_color_we      <= 1'b0;
            pix_depth_we      <= 1'b0;
            pix_depth_replace <= 1'b0;
            pix_color         <= '0;
            pix_depth         <= '0;
        end else begin
            pix_valid    <= 1'b0;
            pix_color_we <= 1'b0;
            pix_depth_we <= 1'b0;
            if (state == ST_EXEC && r_code == pst_pkg::OP_END) begin
                pix_valid         <= 1'b1;
                pix_color_we      <= !kill_flag;
                pix_depth_we      <= !kill_flag;
                pix_depth_replace <= depth_tag;
                pix_color         <= regs[0];
                pix_depth         <= depth_tag ? depth_val : interp_depth;
            end
        end
    end

    assign samp_req        = (state == ST_SAMP);
    assign link.op_ready   = (state == ST_IDLE);
    assign link.res_done   = (state == ST_RESP);
    assign link.res_killed = kill_flag;
    assign link.res_depth  = depth_val;
endmodule

// [rtl/pst_issuer.sv]
`timescale 1ns/100ps
module pst_issuer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    pst_if.iss               link
);
    logic [15:0]     cmd;
    logic            pend;
    logic            killed;
    logic [15:0]     depth;
    logic [5:0]      err;
    logic [5:0]      bad;
    logic [1:0]      dz_cnt;
    logic [7:0]      p1_mask;
    logic [7:0]      sel_seen;
    logic [7:0]      sel_xyw;
    logic            pad_v;
    logic [2:0]      pad_dst;
    logic [2:0]      pad_src;
    logic            dead_v;
    logic [2:0]      dead_idx;
    logic            wr_cmd;
    logic            wr_sts;
    logic [2:0]      c_op, c_src, c_dst;

    assign c_op  = pwdata[pst_pkg::C_OP  +: 3];
    assign c_src = pwdata[pst_pkg::C_SRC +: 3];
    assign c_dst = pwdata[pst_pkg::C_DST +: 3];
    assign wr_cmd = psel && penable && pwrite && pready && paddr == pst_pkg::OFS_CMD;
    assign wr_sts = psel && penable && pwrite && paddr == pst_pkg::OFS_STATUS;

    // legality checks on the program; a bad command is never issued
    always_comb begin
        bad = '0;
        bad[0] = pwdata[pst_pkg::C_DZ] && !(c_op == pst_pkg::OP_LOAD
                 && pwdata[pst_pkg::C_TMP] && pwdata[pst_pkg::C_PH2]);
        bad[1] = pwdata[pst_pkg::C_DZ] && dz_cnt == pst_pkg::DZ_MAX;
        bad[2] = c_op == pst_pkg::OP_LOAD && pwdata[pst_pkg::C_TMP]
                 && !(pwdata[pst_pkg::C_PH2] && p1_mask[c_src]);
        bad[3] = c_op == pst_pkg::OP_LOAD && !pwdata[pst_pkg::C_TMP] && sel_seen[c_src]
                 && sel_xyw[c_src] != pwdata[pst_pkg::C_XYW];
        bad[4] = c_op == pst_pkg::OP_DEPTH && !(pad_v && c_dst == pad_dst + 3'h1
                 && c_src == pad_src && pad_dst > c_src);
        bad[5] = dead_v && c_op != pst_pkg::OP_END
                 && (c_src == dead_idx || c_dst == dead_idx);
    end

    // command hold; apb waits while an earlier one is still pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
            cmd  <= '0;
        end else if (wr_cmd && bad == '0 && !pwdata[pst_pkg::C_START]) begin
            pend <= 1'b1;
            cmd  <= pwdata[15:0];
        end else if (link.op_valid && link.op_ready) begin
            pend <= 1'b0;
        end
    end

    // program tracking, cleared by a start command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dz_cnt   <= '0;
            p1_mask  <= '0;
            sel_seen <= '0;
            sel_xyw  <= '0;
            pad_v    <= 1'b0;
            pad_dst  <= '0;
            pad_src  <= '0;
            dead_v   <= 1'b0;
            dead_idx <= '0;
        end else if (wr_cmd && pwdata[pst_pkg::C_START]) begin
            dz_cnt   <= '0;
            p1_mask  <= '0;
            sel_seen <= '0;
            pad_v    <= 1'b0;
            dead_v   <= 1'b0;
        end else if (wr_cmd && bad == '0) begin
            pad_v <= c_op == pst_pkg::OP_PAD;
            if (pwdata[pst_pkg::C_DZ]) begin
                dz_cnt <= dz_cnt + 2'h1;
            end
            if (c_op == pst_pkg::OP_LOAD && !pwdata[pst_pkg::C_PH2]) begin
                p1_mask[c_dst] <= 1'b1;
            end
            if (c_op == pst_pkg::OP_LOAD && !pwdata[pst_pkg::C_TMP]) begin
                sel_seen[c_src] <= 1'b1;
                sel_xyw[c_src]  <= pwdata[pst_pkg::C_XYW];
            end
            if (c_op == pst_pkg::OP_PAD) begin
                pad_dst <= c_dst;
                pad_src <= c_src;
            end
            if (c_op == pst_pkg::OP_DEPTH) begin
                dead_v   <= 1'b1;
                dead_idx <= c_dst;
            end
        end
    end

    // sticky error bits: write one to clear, a new error wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err <= '0;
        end else begin
            err <= (err & ~(wr_sts ? pwdata[pst_pkg::S_ERR +: pst_pkg::NERR] : 6'h0))
                   | (wr_cmd && !pwdata[pst_pkg::C_START] ? bad : 6'h0);
        end
    end

    // results returned by the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            killed <= 1'b0;
            depth  <= '0;
        end else if (link.res_done) begin
            killed <= link.res_killed;
            depth  <= link.res_depth;
        end
    end

    // apb read mux and answer
    always_comb begin
        prdata = pst_pkg::RST_WORD;
        unique case (paddr)
            pst_pkg::OFS_CMD:    prdata[15:0] = cmd;
            pst_pkg::OFS_STATUS: begin
                prdata[pst_pkg::S_PEND]                  = pend;
                prdata[pst_pkg::S_KILLED]                = killed;
                prdata[pst_pkg::S_ERR +: pst_pkg::NERR]  = err;
                prdata[pst_pkg::S_DZCNT +: 2]            = dz_cnt;
            end
            pst_pkg::OFS_DEPTH:  prdata[15:0] = depth;
            default:             prdata = pst_pkg::RST_WORD;
        endcase
    end

    assign pready  = !(psel && pwrite && paddr == pst_pkg::OFS_CMD && pend);
    assign pslverr = psel && penable && paddr != pst_pkg::OFS_CMD
                     && paddr != pst_pkg::OFS_STATUS && paddr != pst_pkg::OFS_DEPTH;

    assign link.op_valid    = pend;
    assign link.op_code     = cmd[pst_pkg::C_OP +: 3];
    assign link.op_src      = cmd[pst_pkg::C_SRC +: 3];
    assign link.op_src_temp = cmd[pst_pkg::C_TMP];
    assign link.op_dst      = cmd[pst_pkg::C_DST +: 3];
    assign link.op_xyw      = cmd[pst_pkg::C_XYW];
    assign link.op_dw       = cmd[pst_pkg::C_DW];
    assign link.op_dz       = cmd[pst_pkg::C_DZ];
    assign link.op_v14      = cmd[pst_pkg::C_V14];
endmodule

// [testbench/pst_asserts.sv]
`timescale 1ns/100ps
module pst_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        op_valid,
    input wire logic        op_ready,
    input wire logic [2:0]  op_code,
    input wire logic        res_done,
    input wire logic        res_killed,
    input wire logic [15:0] res_depth
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       take;
    logic [2:0] last_op;

    // a handshake moves one op from issuer to device
    assign take = op_valid && op_ready;

    // remember the op in flight, so results can be judged against it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_op <= pst_pkg::OP_END;
        end else if (take) begin
            last_op <= op_code;
        end
    end

    quick_done_a: assert property (take && op_code != pst_pkg::OP_LOAD
        |-> !res_done ##1 !res_done ##1 res_done) else $error("short op late");
    load_early_a: assert property (take && op_code == pst_pkg::OP_LOAD
        |-> ##1 !res_done [*2]) else $error("load done before sample");
    load_late_a: assert property (take && op_code == pst_pkg::OP_LOAD
        |-> ##[3:80] res_done) else $error("load never done");
    done_idle_a: assert property (res_done |-> !op_ready ##1 op_ready)
        else $error("device not idle after done");
    kill_flag_a: assert property ($rose(res_killed) |-> last_op == pst_pkg::OP_KILL)
        else $error("kill flag without kill op");
    kill_hold_a: assert property ($fell(res_killed) |-> last_op == pst_pkg::OP_END)
        else $error("kill flag dropped mid pixel");
    depth_src_a: assert property ($changed(res_depth) |-> last_op == pst_pkg::OP_DEPTH)
        else $error("depth changed by other op");
    op_hold_a: assert property (op_valid && !op_ready
        |=> op_valid && $stable(op_code)) else $error("op dropped before taken");

    cover property (take && op_code == pst_pkg::OP_KILL ##2 res_killed);
    cover property (take && op_code == pst_pkg::OP_LOAD ##[3:80] res_done);
    cover property ($changed(res_depth));
endmodule

// [testbench/pixel_shader_texture_ops_bench.sv]
`timescale 1ns/100ps
module pixel_shader_texture_ops_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, samp_req, pix_valid, pix_color_we;
    logic        pix_depth_we, pix_depth_replace;
    logic        samp_ack = 1'b0;
    logic [2:0]  iter_sel, samp_stage, got_stage, pxf;
    logic [63:0] iter_coord, pix_color, pxc, nx_rgba;
    logic [63:0] samp_rgba = 64'h0;
    logic [63:0] itr [8];
    logic [63:0] ergb [3];
    logic [47:0] samp_coord, got_coord;
    logic [15:0] interp_depth = 16'h0;
    logic [15:0] pix_depth, pxd;
    int          n_mismatch = 0;
    int          checks = 0;
    int          n_samp = 0;
    int          samp_wait = 0;
    int          z, w, dx;

    pst_if lk ();
    pst_issuer pst_issuer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lk));
    pst_device #(.DW(16)) pst_device_i (.pclk(pclk), .presetn(presetn), .link(lk),
        .iter_sel(iter_sel), .iter_coord(iter_coord), .samp_req(samp_req),
        .samp_stage(samp_stage), .samp_coord(samp_coord), .samp_ack(samp_ack),
        .samp_rgba(samp_rgba), .interp_depth(interp_depth), .pix_valid(pix_valid),
        .pix_color_we(pix_color_we), .pix_depth_we(pix_depth_we),
        .pix_depth_replace(pix_depth_replace), .pix_color(pix_color), .pix_depth(pix_depth));
    pst_asserts pst_asserts_i (.pclk(pclk), .presetn(presetn), .op_valid(lk.op_valid),
        .op_ready(lk.op_ready), .op_code(lk.op_code), .res_done(lk.res_done),
        .res_killed(lk.res_killed), .res_depth(lk.res_depth));

    always #4 pclk = ~pclk;
    // iterators answer in the cycle the index is shown
    always_comb iter_coord = itr[iter_sel];

    // sampler: answers after a chosen wait; off the ack the data is scrambled
    always @(posedge pclk) begin
        if (samp_req === 1'b1 && samp_ack !== 1'b1 && samp_wait == 0) begin
            samp_ack <= 1'b1;
            samp_rgba <= nx_rgba;
            got_coord <= samp_coord;
            got_stage <= samp_stage;
            n_samp++;
        end else begin
            samp_ack <= 1'b0;
            samp_rgba <= ~nx_rgba;
            if (samp_req === 1'b1 && samp_wait > 0) samp_wait <= samp_wait - 1;
        end
    end

    // pixel retire capture: {color we, depth we, replace}
    always @(posedge pclk) begin
        if (pix_valid === 1'b1) begin
            pxf <= {pix_color_we, pix_depth_we, pix_depth_replace};
            pxc <= pix_color;
            pxd <= pix_depth;
        end
    end

    // four positive lanes, each big enough to divide by
    function automatic logic [63:0] rg();
        return {2'b01, 14'($urandom), 2'b01, 14'($urandom), 2'b01, 14'($urandom),
                2'b01, 14'($urandom)};
    endfunction

    // q8.8 quotient, truncated
    function automatic logic [15:0] dv(input logic [15:0] a, input logic [15:0] b);
        return 16'((int'(a) * 256) / int'(b));
    endfunction

    function automatic logic [31:0] cw(input logic [2:0] op, input logic [2:0] s,
                                       input logic t, input logic [2:0] d, input logic [4:0] f);
        return {17'h0, f, d, t, s, op};
    endfunction

    task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] gt);
        checks++;
        if (gt !== ex) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, ex, gt);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        rd = prdata;
        er = pslverr;
        if (n >= 300) chk("pready", 1, 0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // issue one op and let it retire
    task automatic run(input logic [31:0] c);
        int k;
        k = 0;
        apb(1'b1, pst_pkg::OFS_CMD, c);
        while (lk.res_done !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 100) chk("res_done", 1, 0);
        @(posedge pclk);
    endtask

    task automatic test_done();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        void'($urandom(32'h8f81));
        for (int i = 0; i < 8; i++) itr[i] = rg();
        nx_rgba = rg();
        interp_depth <= 16'($urandom);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pst_pkg::OFS_STATUS, 0);
        chk("status", pst_pkg::RST_WORD, rd);
        apb(1'b0, pst_pkg::OFS_DEPTH, 0);
        chk("depth", pst_pkg::RST_WORD, rd);
        apb(1'b0, 8'h40, 0);
        chk("pslverr", 1, er);
        $display("test registers ended");
        // x, y or z negative kills; the negative w case reads temp register 1, still zero, and must not
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, pst_pkg::OFS_CMD, 32'h8000);
            itr[1] <= rg() | (64'h8000 << (16 * c));
            run(cw(pst_pkg::OP_KILL, 3'h1, c[1], 3'h0, {c[0], 4'h0}));
            chk("res_killed", c < 3, lk.res_killed);
            run(cw(pst_pkg::OP_END, 3'h0, 1'b0, 3'h0, 5'h0));
            chk("write_en", {c == 3, c == 3}, pxf[2:1]);
            if (c == 3) chk("pix_depth", interp_depth, pxd);
        end
        chk("samples", 0, n_samp);
        $display("test kill ended");
        // plain, w-selected and w-divided loads, one iterator each
        for (int m = 0; m < 3; m++) begin
            itr[m + 2] <= rg();
            nx_rgba <= rg();
            samp_wait <= $urandom % 5;
            run(cw(pst_pkg::OP_LOAD, 3'(m + 2), 1'b0, 3'(m), {3'b100, m == 2, m > 0}));
            ergb[m] = nx_rgba;
            chk("stage", m, got_stage);
            chk("coord", m < 2 ? itr[m + 2][31:0] : {dv(itr[m + 2][31:16], itr[m + 2][63:48]),
                dv(itr[m + 2][15:0], itr[m + 2][63:48])}, got_coord[31:0]);
            if (m < 2) chk("coord_3", m ? itr[m + 2][63:48] : itr[m + 2][47:32],
                got_coord[47:32]);
        end
        // phase two divide by z reads a temp written in phase one
        nx_rgba <= rg();
        run(cw(pst_pkg::OP_LOAD, 3'h1, 1'b1, 3'h4, 5'b11100));
        chk("coord_dz", {dv(ergb[1][31:16], ergb[1][47:32]), dv(ergb[1][15:0], ergb[1][47:32])},
            got_coord[31:0]);
        run(cw(pst_pkg::OP_END, 3'h0, 1'b0, 3'h0, 5'h0));
        chk("color", ergb[0], pxc);
        chk("samples", 4, n_samp);
        // divide by z on an iterator, with a changed selector, is dropped and flagged
        apb(1'b1, pst_pkg::OFS_CMD, cw(pst_pkg::OP_LOAD, 3'h3, 1'b0, 3'h5, 5'b10100));
        apb(1'b0, pst_pkg::OFS_STATUS, 0);
        chk("dz_err", 32'h124, rd);
        apb(1'b1, pst_pkg::OFS_STATUS, 32'h4);
        apb(1'b0, pst_pkg::OFS_STATUS, 0);
        chk("err_clear", 0, rd[pst_pkg::S_ERR]);
        $display("test load ended");
        // depth from two dot products; a zero w gives one
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, pst_pkg::OFS_CMD, 32'h8000);
            itr[2] <= 64'h0200;
            itr[3] <= k ? 64'h0 : 64'h0400;
            nx_rgba <= 64'h0100;
            run(cw(pst_pkg::OP_LOAD, 3'h5, 1'b0, 3'h1, 5'b10000));
            run(cw(pst_pkg::OP_PAD, 3'h1, 1'b1, 3'h2, 5'h0));
            run(cw(pst_pkg::OP_DEPTH, 3'h1, 1'b1, 3'h3, 5'h0));
            z = int'(itr[2][15:0]) * int'(nx_rgba[15:0]) / 256;
            w = int'(itr[3][15:0]) * int'(nx_rgba[15:0]) / 256;
            dx = (w == 0) ? 256 : z * 256 / w;
            chk("res_depth", dx, lk.res_depth);
            apb(1'b0, pst_pkg::OFS_DEPTH, 0);
            chk("depth_reg", dx, rd[15:0]);
            // a second depth op with no pad and a dead destination is refused
            apb(1'b1, pst_pkg::OFS_CMD, cw(pst_pkg::OP_DEPTH, 3'h1, 1'b1, 3'h3, 5'h0));
            apb(1'b0, pst_pkg::OFS_STATUS, 0);
            chk("order_err", 2'b11, rd[7:6]);
            run(cw(pst_pkg::OP_END, 3'h0, 1'b0, 3'h0, 5'h0));
            chk("pix_depth", dx, pxd);
            chk("replace", 3'b111, pxf);
        end
        $display("test depth ended");
        test_done();
    end
endmodule
